// ---- shared/aio_map.svh ----
`ifndef AIO_MAP_SVH
`define AIO_MAP_SVH
`define AIO_WORD_BITS 16
`define AIO_LEAD_BITS 4
`define AIO_DATA_BITS 12
`define AIO_CLK_DIV   4
`define AIO_SYS_MHZ   50
`endif

// ---- shared/aio_pkg.sv ----
package aio_pkg;
  typedef enum logic [1:0] {
    AIO_IDLE = 2'b00,
    AIO_LOW  = 2'b01,
    AIO_HIGH = 2'b11
  } aio_rx_state_t;
  typedef enum logic [1:0] {
    AIO_SYNC  = 2'b00,
    AIO_ASYNC = 2'b01,
    AIO_GATED = 2'b11
  } aio_mode_t;
endpackage : aio_pkg

// ---- shared/aio_if.sv ----
`timescale 1ns/1ps
interface aio_if;
  // open-drain receive lines: enable low means the device pulls/drives
  logic rclk_o, rclk_oe_n;
  logic rfs_o, rfs_oe_n;
  logic rdat_o, rdat_oe_n;
  logic transmit_serial_clock_host, transmit_serial_clock_host_oe_n;
  logic transmit_frame_input, tdat;
  logic rclk, receive_frame_strobe, rdat;   // resolved line levels, set by the bench
  logic transmit_serial_clock_sel_rx;       // 1: transmit clock is the receive clock
  logic tfs_sel_rx;        // 1: transmit frame is the receive frame
  modport dev  (output rclk_o, rclk_oe_n, rfs_o, rfs_oe_n, rdat_o,
                rdat_oe_n, input transmit_serial_clock_host, transmit_frame_input, tdat, rclk,
                transmit_serial_clock_sel_rx, tfs_sel_rx, receive_frame_strobe);
  modport host (input rclk, receive_frame_strobe, rdat, output transmit_serial_clock_host,
                transmit_serial_clock_host_oe_n, transmit_frame_input, tdat, transmit_serial_clock_sel_rx, tfs_sel_rx);
endinterface : aio_if

// ---- rtl/aio_dev.sv ----
`timescale 1ns/1ps
`include "aio_map.svh"
module aio_dev #(
  parameter int WORD_BITS = `AIO_WORD_BITS,
  parameter int CLK_DIV   = `AIO_CLK_DIV
) (
  input  wire logic        I_CLK_SYS,        // system clock
  input  wire logic        I_SYS_RST,        // async reset, high
  aio_if.dev               LNK,              // serial link
  input  wire logic        I_CONVERT_START_INPUT, // convert start pin
  input  wire logic        I_DAC_LATCH_LOAD, // latch load, low active
  input  wire logic        I_CONTINUOUS,     // free-running rclk
  input  wire logic [11:0] I_ADC_RESULT,     // sampled converter code
  output logic      [11:0] O_DAC_CODE,       // dac latch contents
  output logic      [11:0] O_INPUT_LATCH     // input latch contents
);
  initial begin
    if (WORD_BITS != 16 || CLK_DIV < 2)
      $error("aio_dev: unsupported parameters");
  end
  // receive section: device-made clock
  logic [7:0]  div_r, div_nxt;
  logic        rclk_r, rclk_nxt;
  logic [4:0]  rcnt_r, rcnt_nxt;
  logic [15:0] rsh_r, rsh_nxt;
  logic        rfs_r, rfs_nxt;
  logic        rdat_r, rdat_nxt;
  logic [2:0]  cs_s;
  aio_pkg::aio_rx_state_t st_r, st_nxt;
  logic        cs_rise;
  assign cs_rise = cs_s[1] & ~cs_s[2];
  always_comb begin
    div_nxt  = div_r;
    rclk_nxt = rclk_r;
    rcnt_nxt = rcnt_r;
    rsh_nxt  = rsh_r;
    rfs_nxt  = rfs_r;
    rdat_nxt = rdat_r;
    st_nxt   = st_r;
    case (st_r)
      aio_pkg::AIO_IDLE: begin
        div_nxt  = (div_r == 8'(CLK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
        if (I_CONTINUOUS && div_r == 8'(CLK_DIV - 1))
          rclk_nxt = ~rclk_r;
        if (cs_rise) begin
          rfs_nxt  = 1'b0;
          rsh_nxt  = {4'h0, I_ADC_RESULT};
          rdat_nxt = 1'b0;
          rclk_nxt = 1'b1;
          rcnt_nxt = 5'd0;
          div_nxt  = 8'h00;
          st_nxt   = aio_pkg::AIO_HIGH;
        end
      end
      aio_pkg::AIO_HIGH, aio_pkg::AIO_LOW: begin
        div_nxt = (div_r == 8'(CLK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
        if (div_r == 8'(CLK_DIV - 1)) begin
          rclk_nxt = ~rclk_r;
          if (rclk_r) begin
            // falling edge: far end samples rdat_r
            rcnt_nxt = rcnt_r + 5'd1;
            st_nxt   = aio_pkg::AIO_LOW;
          end else begin
            // rising edge: next bit out, msb first
            rsh_nxt  = {rsh_r[14:0], 1'b0};
            rdat_nxt = rsh_r[14];
            st_nxt   = aio_pkg::AIO_HIGH;
            if (rcnt_r == 5'd16) begin
              rfs_nxt  = 1'b1;
              rdat_nxt = 1'b1;  // release data so the pull-up holds idle
              st_nxt  = aio_pkg::AIO_IDLE;
            end
          end
        end
      end
      default: st_nxt = aio_pkg::AIO_IDLE;
    endcase
  end
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      div_r <= 8'h00; rclk_r <= 1'b1; rcnt_r <= 5'd0;
      rsh_r <= 16'h0000; rfs_r <= 1'b1; rdat_r <= 1'b1;
      st_r  <= aio_pkg::AIO_IDLE;
    end else begin
      div_r <= div_nxt; rclk_r <= rclk_nxt; rcnt_r <= rcnt_nxt;
      rsh_r <= rsh_nxt; rfs_r <= rfs_nxt; rdat_r <= rdat_nxt;
      st_r  <= st_nxt;
    end
  end
  // open drain: low enable pulls the line low; gated clock released idle
  assign LNK.rclk_o    = 1'b0;
  assign LNK.rclk_oe_n = (st_r == aio_pkg::AIO_IDLE && !I_CONTINUOUS)
                         ? 1'b1 : rclk_r;
  assign LNK.rfs_o     = 1'b0;
  assign LNK.rfs_oe_n  = rfs_r;
  assign LNK.rdat_o    = 1'b0;
  assign LNK.rdat_oe_n = rdat_r;
  // transmit section: external clock sampled through three flops
  logic [2:0]  transmit_serial_clock_s, tfs_s, td_s, ld_s;
  logic [4:0]  tcnt_r, tcnt_nxt;
  logic [15:0] tsh_r, tsh_nxt;
  logic [11:0] in_r, in_nxt, dac_r, dac_nxt;
  logic        busy_r, busy_nxt, spoil_r, spoil_nxt;
  logic        transmit_serial_clock_raw, tfs_raw, transmit_serial_clock_fall;
  assign transmit_serial_clock_raw  = LNK.transmit_serial_clock_sel_rx ? LNK.rclk : LNK.transmit_serial_clock_host;
  assign tfs_raw   = LNK.tfs_sel_rx ? LNK.receive_frame_strobe : LNK.transmit_frame_input;
  assign transmit_serial_clock_fall = transmit_serial_clock_s[2] & ~transmit_serial_clock_s[1];
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      transmit_serial_clock_s <= 3'b111; tfs_s <= 3'b111; td_s <= 3'b000;
      ld_s <= 3'b111; cs_s <= 3'b000;
    end else begin
      transmit_serial_clock_s <= {transmit_serial_clock_s[1:0], transmit_serial_clock_raw};
      tfs_s  <= {tfs_s[1:0], tfs_raw};
      td_s   <= {td_s[1:0], LNK.tdat};
      ld_s   <= {ld_s[1:0], I_DAC_LATCH_LOAD};
      cs_s   <= {cs_s[1:0], I_CONVERT_START_INPUT};
    end
  end
  always_comb begin
    tcnt_nxt  = tcnt_r;
    tsh_nxt   = tsh_r;
    in_nxt    = in_r;
    dac_nxt   = dac_r;
    busy_nxt  = busy_r;
    spoil_nxt = spoil_r;
    if (busy_r && ld_s[2] != ld_s[1])
      spoil_nxt = 1'b1;
    if (tfs_s[1] && !busy_r) begin
      tcnt_nxt = 5'd0;
    end else if (!tfs_s[1] && tcnt_r == 5'd0 && !busy_r) begin
      busy_nxt  = 1'b1;
      spoil_nxt = 1'b0;
    end
    if (busy_r && transmit_serial_clock_fall) begin
      tsh_nxt  = {tsh_r[14:0], td_s[1]};
      tcnt_nxt = tcnt_r + 5'd1;
      if (tcnt_r == 5'd15) begin
        in_nxt   = {tsh_r[10:0], td_s[1]};
        busy_nxt = 1'b0;
        if (!ld_s[1] && !spoil_r)
          dac_nxt = {tsh_r[10:0], td_s[1]};
      end
    end
    if (!busy_r && ld_s[2] && !ld_s[1])
      dac_nxt = in_r;
  end
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      tcnt_r <= 5'd0; tsh_r <= 16'h0000; in_r <= 12'h000;
      dac_r <= 12'h000; busy_r <= 1'b0; spoil_r <= 1'b0;
    end else begin
      tcnt_r <= tcnt_nxt; tsh_r <= tsh_nxt; in_r <= in_nxt;
      dac_r <= dac_nxt; busy_r <= busy_nxt; spoil_r <= spoil_nxt;
    end
  end
  assign O_DAC_CODE    = dac_r;
  assign O_INPUT_LATCH = in_r;
endmodule : aio_dev

// ---- rtl/aio_host.sv ----
`timescale 1ns/1ps
`include "aio_map.svh"
module aio_host #(
  parameter int CLK_DIV = `AIO_CLK_DIV
) (
  input  wire logic        I_CLK_SYS,    // system clock
  input  wire logic        I_SYS_RST,    // async reset, high
  aio_if.host              LNK,          // serial link
  input  wire logic [1:0]  I_MODE,       // aio_mode_t value
  input  wire logic        I_OWN_CLK,    // async: host makes transmit_serial_clock
  input  wire logic        I_TX_VALID,   // dac word offered
  output logic             O_TX_READY,   // word accepted
  input  wire logic [11:0] I_TX_CODE,    // dac code
  output logic             O_RX_VALID,   // one-cycle pulse
  output logic      [11:0] O_RX_CODE     // received result
);
  initial begin
    if (CLK_DIV < 2) $error("aio_host: CLK_DIV too small");
  end
  logic [2:0]  rc_s, rf_s, rd_s;
  logic [4:0]  rcnt_r, rcnt_nxt, tcnt_r, tcnt_nxt;
  logic [15:0] rsh_r, rsh_nxt, tsh_r, tsh_nxt;
  logic [11:0] rx_r, rx_nxt;
  logic        rv_r, rv_nxt, tbusy_r, tbusy_nxt, tfs_r, tfs_nxt;
  logic [7:0]  div_r, div_nxt;
  logic        transmit_serial_clock_r, transmit_serial_clock_nxt;
  logic        rfall, tfall, syncm, tx_ok;
  logic [2:0]  tq_s;
  assign syncm = (I_MODE != 2'(aio_pkg::AIO_ASYNC)) || !I_OWN_CLK;
  assign rfall = rc_s[2] & ~rc_s[1];
  // own clock: shift as late as the far end samples, so data never races
  assign tfall = syncm ? rfall : (tq_s[2] & ~tq_s[1]);
  // own clock: start only with no fall still in flight to the far end
  assign tx_ok = syncm || (transmit_serial_clock_r && (&tq_s));
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rc_s <= 3'b111; rf_s <= 3'b111; rd_s <= 3'b111;
      tq_s <= 3'b111;
    end else begin
      tq_s <= {tq_s[1:0], transmit_serial_clock_r};
      rc_s <= {rc_s[1:0], LNK.rclk};
      rf_s <= {rf_s[1:0], LNK.receive_frame_strobe};
      rd_s <= {rd_s[1:0], LNK.rdat};
    end
  end
  always_comb begin
    rcnt_nxt = rcnt_r; rsh_nxt = rsh_r; rx_nxt = rx_r; rv_nxt = 1'b0;
    tcnt_nxt = tcnt_r; tsh_nxt = tsh_r; tbusy_nxt = tbusy_r;
    tfs_nxt = tfs_r; div_nxt = div_r; transmit_serial_clock_nxt = transmit_serial_clock_r;
    O_TX_READY = !tbusy_r && tx_ok;
    if (rf_s[1] && I_MODE != 2'(aio_pkg::AIO_GATED))
      rcnt_nxt = 5'd0;
    else if (rfall) begin
      rsh_nxt  = {rsh_r[14:0], rd_s[1]};
      rcnt_nxt = rcnt_r + 5'd1;
      if (rcnt_r == 5'd15) begin
        rx_nxt   = {rsh_r[10:0], rd_s[1]};
        rv_nxt   = 1'b1;
        rcnt_nxt = 5'd0;
      end
    end
    if (!syncm) begin
      div_nxt = (div_r == 8'(CLK_DIV - 1)) ? 8'h00 : div_r + 8'h01;
      if (div_r == 8'(CLK_DIV - 1)) transmit_serial_clock_nxt = ~transmit_serial_clock_r;
    end
    if (!tbusy_r && tx_ok && I_TX_VALID) begin
      tbusy_nxt = 1'b1;
      if (!syncm) begin
        div_nxt  = 8'h00;
        transmit_serial_clock_nxt = 1'b1;
      end
      tsh_nxt   = {4'h0, I_TX_CODE};
      tcnt_nxt  = 5'd0;
      tfs_nxt   = 1'b0;
    end else if (tbusy_r && tfall) begin
      tsh_nxt  = {tsh_r[14:0], 1'b0};
      tcnt_nxt = tcnt_r + 5'd1;
      if (tcnt_r == 5'd15) begin
        tbusy_nxt = 1'b0;
        tfs_nxt   = 1'b1;
      end
    end
  end
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rcnt_r <= 5'd0; rsh_r <= 16'h0000; rx_r <= 12'h000; rv_r <= 1'b0;
      tcnt_r <= 5'd0; tsh_r <= 16'h0000; tbusy_r <= 1'b0; tfs_r <= 1'b1;
      div_r <= 8'h00; transmit_serial_clock_r <= 1'b1;
    end else begin
      rcnt_r <= rcnt_nxt; rsh_r <= rsh_nxt; rx_r <= rx_nxt;
      rv_r <= rv_nxt; tcnt_r <= tcnt_nxt; tsh_r <= tsh_nxt;
      tbusy_r <= tbusy_nxt; tfs_r <= tfs_nxt; div_r <= div_nxt;
      transmit_serial_clock_r <= transmit_serial_clock_nxt;
    end
  end
  // line count: sync 4, gated 4, async 5 or 6
  assign LNK.transmit_serial_clock_sel_rx    = syncm;
  assign LNK.tfs_sel_rx     = (I_MODE != 2'(aio_pkg::AIO_ASYNC));
  assign LNK.transmit_serial_clock_host      = transmit_serial_clock_r;
  assign LNK.transmit_serial_clock_host_oe_n = syncm;
  assign LNK.transmit_frame_input            = tfs_r;
  assign LNK.tdat           = tsh_r[15];
  assign O_RX_VALID         = rv_r;
  assign O_RX_CODE          = rx_r;
endmodule : aio_host

// ---- verif/aio_link_props.sv ----
`timescale 1ns/1ps
module aio_link_props (
  input wire logic I_CLK_SYS,  // system clock
  input wire logic I_SYS_RST,  // async reset, high
  input wire logic rclk,       // resolved receive clock
  input wire logic receive_frame_strobe,        // resolved receive frame
  input wire logic rdat,       // resolved receive data
  input wire logic rclk_oe_n,  // clock driven when low
  input wire logic rdat_oe_n   // data driven when low
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);
  logic [4:0] falls_r;
  logic [4:0] falls_nxt;
  logic       rclk_q_r;
  // falls seen inside the frame; cleared only once the frame is idle
  always_comb begin
    falls_nxt = falls_r;
    if (receive_frame_strobe) begin
      falls_nxt = 5'h00;
    end else if (rclk_q_r && !rclk) begin
      falls_nxt = falls_r + 5'h01;
    end
  end
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      falls_r  <= 5'h00;
      rclk_q_r <= 1'b1;
    end else begin
      falls_r  <= falls_nxt;
      rclk_q_r <= rclk;
    end
  end
  AST_FALLS_16 : assert property ($rose(receive_frame_strobe) |-> falls_r == 5'h10)
    else $error("frame ended without sixteen clock falls");
  AST_LEAD_ZEROS : assert property
    ((!receive_frame_strobe && $fell(rclk) && falls_r < 5'h04) |-> !rdat)
    else $error("leading bit not zero");
  AST_CHANGE_ON_RISE : assert property
    ((!receive_frame_strobe && $past(!receive_frame_strobe) && $changed(rdat)) |-> rclk)
    else $error("data changed while clock low");
  AST_HALF_PERIOD : assert property
    (($rose(rclk) && !receive_frame_strobe && $past(!receive_frame_strobe)) |-> rclk[*4] ##1 !rclk)
    else $error("clock high phase wrong length");
  AST_RCLK_RELEASE : assert property ($rose(receive_frame_strobe) |-> ##[0:4] rclk_oe_n)
    else $error("clock not released after word");
  AST_IDLE_RELEASED : assert property
    ((receive_frame_strobe && $past(receive_frame_strobe, 8)) |-> rclk_oe_n)
    else $error("clock driven while idle");
  AST_RDAT_RELEASED : assert property
    ((receive_frame_strobe && $past(receive_frame_strobe, 2)) |-> rdat_oe_n)
    else $error("data driven outside frame");
  AST_CLK_IN_FRAME : assert property
    ((!receive_frame_strobe && rclk) |-> ##[1:5] (!rclk || receive_frame_strobe))
    else $error("clock stuck high inside frame");
endmodule : aio_link_props

// ---- verif/adc_dac_dual_serial_port_tb.sv ----
`timescale 1ns/1ps
module adc_dac_dual_serial_port_tb;
  logic        clk, rst, cs, dac_latch_load, own, txv, txr, rxv;
  logic [1:0]  mode;
  logic [11:0] adc, txc, rxc, dac, ilat;
  int          mismatches, checks, cyc, n;
  logic [11:0] rxq[$];
  aio_if lnk();
  // open-drain lines idle at the pull-up level
  assign lnk.rclk = lnk.rclk_oe_n ? 1'b1 : lnk.rclk_o;
  assign lnk.receive_frame_strobe  = lnk.rfs_oe_n ? 1'b1 : lnk.rfs_o;
  assign lnk.rdat = lnk.rdat_oe_n ? 1'b1 : lnk.rdat_o;
  aio_dev i_aio_dev (.I_CLK_SYS(clk), .I_SYS_RST(rst), .LNK(lnk),
    .I_CONVERT_START_INPUT(cs), .I_DAC_LATCH_LOAD(dac_latch_load),
    .I_CONTINUOUS(1'b0), .I_ADC_RESULT(adc), .O_DAC_CODE(dac),
    .O_INPUT_LATCH(ilat));
  aio_host i_aio_host (.I_CLK_SYS(clk), .I_SYS_RST(rst), .LNK(lnk),
    .I_MODE(mode), .I_OWN_CLK(own), .I_TX_VALID(txv), .O_TX_READY(txr),
    .I_TX_CODE(txc), .O_RX_VALID(rxv), .O_RX_CODE(rxc));
  aio_link_props i_aio_link_props (.I_CLK_SYS(clk), .I_SYS_RST(rst),
    .rclk(lnk.rclk), .receive_frame_strobe(lnk.receive_frame_strobe), .rdat(lnk.rdat),
    .rclk_oe_n(lnk.rclk_oe_n), .rdat_oe_n(lnk.rdat_oe_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input string what, input logic [11:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // receive model: every delivered result must match one started word
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
    if (rxv === 1'b1) begin
      check("rx_count", 12'(rxq.size()), 12'h001);
      if (rxq.size() > 0) check("rx_code", rxc, rxq.pop_front());
    end
  end
  // k: 0 load held low, 1 load falls after word, 2 load and start mid-word
  task automatic run(input logic [1:0] m, input logic o, input int k);
    logic [11:0] code, old;
    old = dac;
    code = 12'($urandom);
    mode <= m;
    own <= o;
    dac_latch_load <= (k != 0);
    adc <= 12'($urandom);
    repeat (4) @(posedge clk);
    txv <= 1'b1;
    txc <= code;
    n = 0;
    do begin @(posedge clk); n++; end while (txr !== 1'b1 && n < 500);
    txv <= 1'b0;
    check("transmit_serial_clock_sel", 12'(lnk.transmit_serial_clock_sel_rx),
          12'(!(o && m == aio_pkg::AIO_ASYNC)));
    check("tfs_sel", 12'(lnk.tfs_sel_rx),
          12'(m != aio_pkg::AIO_ASYNC));
    rxq.push_back(adc);
    cs <= 1'b1;
    n = 0;
    do begin @(posedge clk); #1 n++; end while (lnk.receive_frame_strobe !== 1'b0 && n < 20);
    check("rfs_delay", 12'(n), 12'h003);
    @(posedge clk);
    cs <= 1'b0;
    if (k == 2) begin
      repeat (20) @(posedge clk);
      dac_latch_load <= 1'b0;
      cs <= 1'b1;
      repeat (10) @(posedge clk);
      dac_latch_load <= 1'b1;
      cs <= 1'b0;
    end
    n = 0;
    while (rxq.size() > 0 && n < 400) begin @(posedge clk); n++; end
    repeat (o ? 300 : 40) @(posedge clk);
    check("input_latch", ilat, code);
    check("dac_hold", dac, (k == 0) ? code : old);
    if (k == 1) begin
      dac_latch_load <= 1'b0;
      repeat (6) @(posedge clk);
      check("dac_load", dac, code);
    end
    $display("test mode %0d own %0d kind %0d done", m, o, k);
  endtask : run
  initial begin
    rst = 1'b1;
    cs = 1'b0;
    dac_latch_load = 1'b1;
    own = 1'b0;
    txv = 1'b0;
    mode = aio_pkg::AIO_SYNC;
    adc = 12'h000;
    txc = 12'h000;
    mismatches = 0;
    checks = 0;
    cyc = 0;
    void'($urandom(88));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check("dac_reset", dac, 12'h000);
    run(aio_pkg::AIO_SYNC, 1'b0, 0);
    run(aio_pkg::AIO_SYNC, 1'b0, 1);
    run(aio_pkg::AIO_SYNC, 1'b0, 2);
    run(aio_pkg::AIO_ASYNC, 1'b0, 1);
    run(aio_pkg::AIO_ASYNC, 1'b1, 0);
    run(aio_pkg::AIO_GATED, 1'b0, 0);
    run(aio_pkg::AIO_GATED, 1'b0, 2);
    for (int i = 0; i < 3; i++) begin
      run(aio_pkg::AIO_SYNC, 1'b0, 0);
    end
    wrap_up();
  end
endmodule : adc_dac_dual_serial_port_tb
